// ### inc/tcp_pkg.sv
package tcp_pkg;

  // core clock
  localparam real CLK_PERIOD_NS = 10.0;

  // longest 9-bit conversion time; the other resolutions double it per step
  localparam real CONV9_TIME_MS = 93.75;
  localparam int unsigned CONV9_CYC = int'($floor(CONV9_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CNT_W = 27;

  // nonvolatile write cycle shown as busy
  localparam real NV_WRITE_TIME_MS = 10.0;
  localparam int unsigned NV_WRITE_CYC = int'($ceil(NV_WRITE_TIME_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int NV_CNT_W = 20;

  // word widths
  localparam int CMD_W = 8;
  localparam int THR_W = 12;
  localparam int CFG_W = 8;
  localparam int RD_W = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] CMD_LAST_BIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] THR_LAST_BIT = 4'hb;
  localparam logic [BIT_CNT_W-1:0] CFG_LAST_BIT = 4'h7;

  // command codes
  localparam logic [CMD_W-1:0] CMD_START_CONV = 8'h51;
  localparam logic [CMD_W-1:0] CMD_STOP_CONV = 8'h22;
  localparam logic [CMD_W-1:0] CMD_FETCH_TEMP = 8'haa;
  localparam logic [CMD_W-1:0] CMD_FETCH_UPPER_LIMIT = 8'ha1;
  localparam logic [CMD_W-1:0] CMD_FETCH_LOWER_LIMIT = 8'ha2;
  localparam logic [CMD_W-1:0] CMD_STORE_UPPER_LIMIT = 8'h01;
  localparam logic [CMD_W-1:0] CMD_STORE_LOWER_LIMIT = 8'h02;
  localparam logic [CMD_W-1:0] CMD_FETCH_SETUP = 8'hac;
  localparam logic [CMD_W-1:0] CMD_STORE_SETUP = 8'h0c;
  localparam logic [CMD_W-1:0] CMD_SOFT_POR = 8'h54;

  // conversion_setup_register fields
  localparam int CFG_CONV_DONE = 7;
  localparam int CFG_OVER_FLAG = 6;
  localparam int CFG_UNDER_FLAG = 5;
  localparam int CFG_NV_BUSY = 4;
  localparam int CFG_RES_HI = 3;
  localparam int CFG_RES_LO = 2;
  localparam int CFG_ONE_SHOT = 0;
  localparam int NV_W = 4;
  localparam logic [NV_W-1:0] NV_FACTORY = 4'hc;
  localparam logic [THR_W-1:0] THR_FACTORY = 12'h000;
  localparam logic [THR_W-1:0] TEMP_POWERUP = 12'h000;

  typedef enum logic [3:0] {
    PH_CMD = 4'b0001,
    PH_WRITE = 4'b0010,
    PH_READ = 4'b0100,
    PH_HOLD = 4'b1000
  } tcp_phase_t;

  typedef enum logic [1:0] {
    CV_IDLE = 2'b01,
    CV_RUN = 2'b10
  } tcp_conv_state_t;

  // unused low bits per resolution read as zero
  function automatic logic [THR_W-1:0] resMask(input logic [1:0] res);
    case (res)
      2'h0: resMask = 12'hff8;
      2'h1: resMask = 12'hffc;
      2'h2: resMask = 12'hffe;
      default: resMask = 12'hfff;
    endcase
  endfunction

endpackage

// ### inc/tcp_conv_if.sv
interface tcp_conv_if;
  logic startReq;
  logic stopReq;
  logic haltReq;
  logic oneShot;
  logic [1:0] resolution;
  logic busy;
  logic convDone;

  modport ctrl (
    output startReq, stopReq, haltReq, oneShot, resolution,
    input busy, convDone
  );

  modport timer (
    input startReq, stopReq, haltReq, oneShot, resolution,
    output busy, convDone
  );
endinterface

// ### src/tcp_conv_timer.sv
module tcp_conv_timer
  import tcp_pkg::*;
#(
  parameter int unsigned BASE_CYC = CONV9_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // conversion control
  tcp_conv_if.timer conv
);

  tcp_conv_state_t stateQ;
  logic [CNT_W-1:0] cntQ;
  logic contQ;
  logic doneQ;
  logic [CNT_W-1:0] loadVal;
  logic stopNow;

  assign loadVal = CNT_W'(BASE_CYC) << conv.resolution;
  assign stopNow = conv.stopReq && contQ;
  assign conv.busy = (stateQ == CV_RUN);
  assign conv.convDone = doneQ;

  always_ff @(posedge core_clk) begin
    if (rst || conv.haltReq) begin
      stateQ <= CV_IDLE;
      cntQ <= '0;
      contQ <= 1'b0;
    end else begin
      case (stateQ)
        CV_IDLE: begin
          if (conv.startReq) begin
            stateQ <= CV_RUN;
            cntQ <= loadVal - 1'b1;
            contQ <= !conv.oneShot;
          end
        end
        CV_RUN: begin
          // a stop while in one-shot mode is ignored
          if (stopNow) begin
            stateQ <= CV_IDLE;
          end else if (cntQ == '0) begin
            if (contQ) begin
              cntQ <= loadVal - 1'b1;
            end else begin
              stateQ <= CV_IDLE;
            end
          end else begin
            cntQ <= cntQ - 1'b1;
          end
        end
        default: stateQ <= CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || conv.haltReq) begin
      doneQ <= 1'b0;
    end else begin
      doneQ <= (stateQ == CV_RUN) && (cntQ == '0) && !stopNow;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_start_runs: assert property ((stateQ == CV_IDLE) && conv.startReq && !conv.haltReq |=> conv.busy)
    else $error("start did not begin a conversion");
  a_oneshot_ends: assert property (conv.busy && !contQ && (cntQ == '0) && !conv.haltReq |=> !conv.busy ##0 conv.convDone)
    else $error("one-shot conversion did not stop after one result");
  a_cont_repeats: assert property (conv.busy && contQ && (cntQ == '0) && !conv.stopReq && !conv.haltReq
                                   |=> conv.busy && conv.convDone)
    else $error("continuous conversion did not restart");
  a_stop_halts: assert property (conv.busy && contQ && conv.stopReq && !conv.haltReq |=> !conv.busy [*2])
    else $error("stop left continuous conversion running");
  a_res_time: assert property ((stateQ == CV_IDLE) && conv.startReq && !conv.haltReq
                               |=> cntQ == (CNT_W'(BASE_CYC) << $past(conv.resolution)) - 1'b1)
    else $error("conversion time does not match resolution");

endmodule

// ### src/tcp_cmd_port.sv
// How it works
// - one-shot mode: single conversion, then standby
// - continuous mode: convert until stop command
// - resolution bits pick length and conversion time
// - all bus words travel least bit first
// - select high opens, low ends, releases data
// - drive on falling edge, release after rising
// - start, stop, reset commands have no data
// - threshold write keeps first twelve bits only
// - commit only after full bit count arrives
// - read data starts right after command byte
// - after response, zeros until select drops
// - code 51h starts conversions
// - code 22h stops continuous conversions
// - AAh temperature, A1h high, A2h low threshold
// - codes 01h, 02h write high, low thresholds
// - ACh reads, 0Ch writes setup byte
// - code 54h restores power-up state, halts conversion
// - setup byte bit order done through one-shot
// - resolution, standalone, one-shot bits are nonvolatile
module tcp_cmd_port
  import tcp_pkg::*;
#(
  parameter int unsigned CONV_BASE_CYC = CONV9_CYC,
  parameter int unsigned NV_WRITE_CYC_P = NV_WRITE_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // three-wire bus pins
  input wire logic chipSelect,
  input wire logic busClockOrConvertPin,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOe,
  // temperature front end
  input wire logic [THR_W-1:0] sensorTemp,
  output logic convBusy
);

  tcp_conv_if conv ();

  // pin synchronisers: [0] meta, [1] synced, [2] previous
  logic [1:0] selPipeQ;
  logic [2:0] clkPipeQ;
  logic [1:0] dqPipeQ;
  logic selActive;
  logic riseEdge;
  logic fallEdge;
  logic dqSample;

  // serial engine
  tcp_phase_t phaseQ;
  tcp_phase_t nextPhase;
  logic [BIT_CNT_W-1:0] bitCntQ;
  logic [CMD_W-1:0] cmdShiftQ;
  logic [CMD_W-1:0] cmdQ;
  logic [CMD_W-1:0] cmdNext;
  logic [THR_W-1:0] wrShiftQ;
  logic [THR_W-1:0] wrWord;
  logic [CFG_W-1:0] wrByte;
  logic [BIT_CNT_W-1:0] wrLastBit;
  logic cmdDone;
  logic wrCommit;
  logic porReq;

  // response path
  logic [RD_W-1:0] rdShiftQ;
  logic [RD_W-1:0] readWord;
  logic dataOutQ;
  logic dataOeQ;

  // register state
  logic [NV_W-1:0] nvCfgQ;
  logic [THR_W-1:0] thHighQ;
  logic [THR_W-1:0] thLowQ;
  logic [THR_W-1:0] tempQ;
  logic [THR_W-1:0] tempMasked;
  logic [THR_W-1:0] curMask;
  logic overFlagQ;
  logic underFlagQ;
  logic overSet;
  logic underSet;
  logic [NV_CNT_W-1:0] nvCntQ;
  logic nvBusy;
  logic [CFG_W-1:0] cfgByte;
  logic cfgWrite;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      selPipeQ <= '0;
      clkPipeQ <= '0;
      dqPipeQ <= '0;
    end else begin
      selPipeQ <= {selPipeQ[0], chipSelect};
      clkPipeQ <= {clkPipeQ[1:0], busClockOrConvertPin};
      dqPipeQ <= {dqPipeQ[0], dataIn};
    end
  end

  assign selActive = selPipeQ[1];
  assign riseEdge = clkPipeQ[1] && !clkPipeQ[2];
  assign fallEdge = !clkPipeQ[1] && clkPipeQ[2];
  // data travels the same two stages as the clock, so it is taken as the host held it
  assign dqSample = dqPipeQ[1];

  // commands shift in from the top, so the first bit ends at bit 0
  assign cmdNext = {dqSample, cmdShiftQ[CMD_W-1:1]};
  assign wrWord = {dqSample, wrShiftQ[THR_W-1:1]};
  assign wrByte = wrWord[THR_W-1:THR_W-CFG_W];
  assign wrLastBit = (cmdQ == CMD_STORE_SETUP) ? CFG_LAST_BIT : THR_LAST_BIT;

  always_comb begin
    case (cmdNext)
      CMD_STORE_UPPER_LIMIT, CMD_STORE_LOWER_LIMIT, CMD_STORE_SETUP: nextPhase = PH_WRITE;
      CMD_FETCH_TEMP, CMD_FETCH_UPPER_LIMIT, CMD_FETCH_LOWER_LIMIT, CMD_FETCH_SETUP: nextPhase = PH_READ;
      default: nextPhase = PH_HOLD;
    endcase
  end

  assign cmdDone = selActive && riseEdge && (phaseQ == PH_CMD) && (bitCntQ == CMD_LAST_BIT);
  assign wrCommit = selActive && riseEdge && (phaseQ == PH_WRITE) && (bitCntQ == wrLastBit);
  assign porReq = cmdDone && (cmdNext == CMD_SOFT_POR);
  assign cfgWrite = wrCommit && (cmdQ == CMD_STORE_SETUP);

  // dropping select anywhere returns to command phase, losing a partial write
  always_ff @(posedge core_clk) begin
    if (rst || !selActive) begin
      phaseQ <= PH_CMD;
      bitCntQ <= '0;
    end else if (riseEdge) begin
      case (phaseQ)
        PH_CMD: begin
          if (bitCntQ == CMD_LAST_BIT) begin
            bitCntQ <= '0;
            phaseQ <= nextPhase;
          end else begin
            bitCntQ <= bitCntQ + 1'b1;
          end
        end
        PH_WRITE: begin
          if (wrCommit) begin
            phaseQ <= PH_HOLD;
          end else begin
            bitCntQ <= bitCntQ + 1'b1;
          end
        end
        default: phaseQ <= phaseQ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmdShiftQ <= '0;
      cmdQ <= '0;
      wrShiftQ <= '0;
    end else if (selActive && riseEdge) begin
      if (phaseQ == PH_CMD) begin
        cmdShiftQ <= cmdNext;
      end
      if (cmdDone) begin
        cmdQ <= cmdNext;
      end
      if (phaseQ == PH_WRITE) begin
        wrShiftQ <= wrWord;
      end
    end
  end

  always_comb begin
    case (cmdNext)
      CMD_FETCH_TEMP: readWord = {{(RD_W-THR_W){1'b0}}, tempQ};
      CMD_FETCH_UPPER_LIMIT: readWord = {{(RD_W-THR_W){1'b0}}, thHighQ};
      CMD_FETCH_LOWER_LIMIT: readWord = {{(RD_W-THR_W){1'b0}}, thLowQ};
      CMD_FETCH_SETUP: readWord = {{(RD_W-CFG_W){1'b0}}, cfgByte};
      default: readWord = '0;
    endcase
  end

  // zeros fill in behind the response, so the tail reads as zero
  always_ff @(posedge core_clk) begin
    if (rst || !selActive) begin
      rdShiftQ <= '0;
      dataOutQ <= 1'b0;
      dataOeQ <= 1'b0;
    end else if (cmdDone) begin
      rdShiftQ <= readWord;
      dataOeQ <= 1'b0;
    end else if ((phaseQ == PH_READ) && fallEdge) begin
      dataOeQ <= 1'b1;
      dataOutQ <= rdShiftQ[0];
      rdShiftQ <= {1'b0, rdShiftQ[RD_W-1:1]};
    end else if (riseEdge) begin
      dataOeQ <= 1'b0;
    end
  end

  assign dataOut = dataOutQ;
  assign dataOe = dataOeQ;

  // conversion control
  assign conv.startReq = cmdDone && (cmdNext == CMD_START_CONV);
  assign conv.stopReq = cmdDone && (cmdNext == CMD_STOP_CONV);
  assign conv.haltReq = porReq;
  assign conv.oneShot = nvCfgQ[CFG_ONE_SHOT];
  assign conv.resolution = nvCfgQ[CFG_RES_LO +: 2];
  assign convBusy = conv.busy;

  tcp_conv_timer #(
    .BASE_CYC(CONV_BASE_CYC)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .conv(conv.timer)
  );

  assign curMask = resMask(conv.resolution);
  assign tempMasked = sensorTemp & curMask;

  // nonvolatile: survives the software reset, only a hard reset loads factory values
  always_ff @(posedge core_clk) begin
    if (rst) begin
      nvCfgQ <= NV_FACTORY;
      thHighQ <= THR_FACTORY;
      thLowQ <= THR_FACTORY;
    end else if (wrCommit) begin
      case (cmdQ)
        CMD_STORE_UPPER_LIMIT: thHighQ <= wrWord & curMask;
        CMD_STORE_LOWER_LIMIT: thLowQ <= wrWord & curMask;
        CMD_STORE_SETUP: nvCfgQ <= wrByte[NV_W-1:0];
        default: nvCfgQ <= nvCfgQ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || porReq) begin
      tempQ <= TEMP_POWERUP;
    end else if (conv.convDone) begin
      tempQ <= tempMasked;
    end
  end

  assign overSet = conv.convDone && ($signed(tempMasked) >= $signed(thHighQ));
  assign underSet = conv.convDone && ($signed(tempMasked) <= $signed(thLowQ));

  // a flag raised in the cycle software clears it stays raised
  always_ff @(posedge core_clk) begin
    if (rst || porReq) begin
      overFlagQ <= 1'b0;
      underFlagQ <= 1'b0;
    end else begin
      overFlagQ <= overSet || (cfgWrite ? wrByte[CFG_OVER_FLAG] : overFlagQ);
      underFlagQ <= underSet || (cfgWrite ? wrByte[CFG_UNDER_FLAG] : underFlagQ);
    end
  end

  // busy shown only; a write inside the window is still accepted
  always_ff @(posedge core_clk) begin
    if (rst || porReq) begin
      nvCntQ <= '0;
    end else if (wrCommit) begin
      nvCntQ <= NV_CNT_W'(NV_WRITE_CYC_P);
    end else if (nvBusy) begin
      nvCntQ <= nvCntQ - 1'b1;
    end
  end

  assign nvBusy = (nvCntQ != '0);
  assign cfgByte = {!conv.busy, overFlagQ, underFlagQ, nvBusy, nvCfgQ};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_deselect_float: assert property (!selActive |=> !dataOeQ)
    else $error("data pin driven while deselected");
  a_drive_lsb: assert property (selActive && fallEdge && (phaseQ == PH_READ)
                                |=> dataOeQ && (dataOutQ == $past(rdShiftQ[0])))
    else $error("read bit not driven on falling edge");
  a_release_rise: assert property (riseEdge && !cmdDone |=> !dataOeQ)
    else $error("data pin not released after rising edge");
  a_read_order: assert property (cmdDone && (nextPhase == PH_READ) |=> (rdShiftQ == $past(readWord))
                                 ##0 (phaseQ == PH_READ))
    else $error("read response not loaded after command");
  a_zero_tail: assert property (selActive && fallEdge && (phaseQ == PH_READ) |=> !rdShiftQ[RD_W-1])
    else $error("response tail not zero filled");
  a_quiet_idle: assert property ((phaseQ != PH_READ) |-> !dataOeQ)
    else $error("data pin driven outside a read");
  a_no_data_cmds: assert property (cmdDone && ((cmdNext == CMD_START_CONV) || (cmdNext == CMD_STOP_CONV))
                                   |=> (phaseQ == PH_HOLD))
    else $error("command without data entered a data phase");
  a_thr_commit: assert property (wrCommit && (cmdQ == CMD_STORE_UPPER_LIMIT)
                                 |=> thHighQ == ($past(wrWord) & $past(curMask)))
    else $error("high threshold not written");
  a_extra_ignored: assert property ((phaseQ == PH_HOLD) |=> $stable(thHighQ) && $stable(thLowQ))
    else $error("bits beyond the word changed a threshold");
  a_short_drop: assert property ((phaseQ == PH_WRITE) && !selActive
                                 |=> $stable(thHighQ) && $stable(thLowQ) && $stable(nvCfgQ))
    else $error("partial write was committed");
  a_setup_commit: assert property (cfgWrite |=> nvCfgQ == $past(wrByte[NV_W-1:0]))
    else $error("setup byte not stored");
  a_por_clears: assert property (porReq |=> !overFlagQ && !underFlagQ && (tempQ == TEMP_POWERUP) && !conv.busy)
    else $error("software reset did not restore power-up state");

  // flags, temperature capture, nonvolatile state, phases and bit counters
  a_over_set: assert property (overSet && !porReq |=> overFlagQ)
    else $error("over flag not raised by conversion");
  a_under_set: assert property (underSet && !porReq |=> underFlagQ)
    else $error("under flag not raised by conversion");
  a_flag_write: assert property (cfgWrite && !overSet && !underSet && !porReq
                                 |=> (overFlagQ == $past(wrByte[CFG_OVER_FLAG])) && (underFlagQ == $past(wrByte[CFG_UNDER_FLAG])))
    else $error("flag write from setup byte lost");
  a_nv_busy: assert property (wrCommit |=> nvBusy)
    else $error("nonvolatile busy not shown after write");
  a_low_commit: assert property (wrCommit && (cmdQ == CMD_STORE_LOWER_LIMIT)
                                 |=> thLowQ == ($past(wrWord) & $past(curMask)))
    else $error("low threshold not written");
  a_temp_capture: assert property (conv.convDone && !porReq |=> tempQ == $past(tempMasked))
    else $error("conversion result not captured");
  a_por_keeps_nv: assert property (porReq
                                   |=> $stable(nvCfgQ) && $stable(thHighQ) && $stable(thLowQ))
    else $error("software reset lost nonvolatile state");
  a_select_restart: assert property (!selActive
                                     |=> (phaseQ == PH_CMD) && (bitCntQ == '0))
    else $error("deselect did not return to command phase");
  a_unknown_quiet: assert property (cmdDone && (nextPhase == PH_HOLD)
                                    |=> (phaseQ == PH_HOLD) && !dataOeQ)
    else $error("command without response drove the pin");
  a_write_count: assert property ((phaseQ == PH_WRITE) |-> (bitCntQ <= wrLastBit))
    else $error("write bit count ran past word length");
  a_cmd_count: assert property ((phaseQ == PH_CMD) |-> (bitCntQ <= CMD_LAST_BIT))
    else $error("command bit count ran past byte length");

endmodule

// ### tb/tcp_host_model.sv
module tcp_host_model (
  // system clock
  input wire logic core_clk,
  // bus pins
  output logic chipSelect,
  output logic busClk,
  output logic dataLine,
  input wire logic dataOut,
  input wire logic dataOe,
  // transfer result: released flag over the read bits
  output logic resValid,
  output logic [16:0] resWord
);
  timeunit 1ns;
  timeprecision 1ps;

  logic mOe;
  logic mBit;
  logic floatBit;

  initial begin
    chipSelect = 1'b0;
    busClk = 1'b0;
    mOe = 1'b0;
    mBit = 1'b0;
    floatBit = 1'b0;
    resValid = 1'b0;
    resWord = '0;
  end

  // no pull on the wire: a released line wanders, so a stale bit never reads as good
  always @(posedge core_clk) begin
    floatBit <= ~floatBit;
  end
  assign dataLine = dataOe ? dataOut : (mOe ? mBit : floatBit);

  // bus clock runs only inside frames, 125 ns period, unrelated to core_clk
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nOut, input int nIn);
    logic [15:0] rd;
    rd = 'x;
    chipSelect = 1'b1;
    #100;
    for (int i = 0; i < 8 + nOut + nIn; i++) begin
      mOe = (i < 8 + nOut);
      mBit = (i < 8) ? cmd[3'(i)] : wd[4'(i - 8)];
      #62.5;
      if (i >= 8 + nOut) rd[i - 8 - nOut] = dataOe ? dataOut : 1'bx;
      busClk = 1'b1;
      #55;
      // pin must be released again before the next falling edge
      if (i >= 8 + nOut && dataOe) rd[i - 8 - nOut] = 1'bx;
      #7.5;
      busClk = 1'b0;
    end
    mOe = 1'b0;
    #60;
    chipSelect = 1'b0;
    #60;
    resWord = {~dataOe, rd};
    resValid = 1'b1;
    #10;
    resValid = 1'b0;
    #200;
  endtask
endmodule

// ### tb/tcp_cmd_port_tb.sv
module tcp_cmd_port_tb;
  import tcp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned BASE = 20;
  logic core_clk, rst, chipSelect, busClk, dataLine, dataOut, dataOe, convBusy, resValid;
  logic [THR_W-1:0] sensorTemp;
  logic [16:0] resWord;
  logic [16:0] expQ[$];
  logic [31:0] rng;
  int err_count, compares;
  int busyRun = 0;
  int busyLen = 0;
  int convEnds = 0;

  tcp_cmd_port #(.CONV_BASE_CYC(BASE), .NV_WRITE_CYC_P(10)) tcp_cmd_port_i (
    .core_clk(core_clk), .rst(rst), .chipSelect(chipSelect), .busClockOrConvertPin(busClk),
    .dataIn(dataLine), .dataOut(dataOut), .dataOe(dataOe), .sensorTemp(sensorTemp), .convBusy(convBusy));
  tcp_host_model tcp_host_model_i (
    .core_clk(core_clk), .chipSelect(chipSelect), .busClk(busClk), .dataLine(dataLine),
    .dataOut(dataOut), .dataOe(dataOe), .resValid(resValid), .resWord(resWord));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // note the expectation, then let the host run the frame
  task automatic run(input logic [7:0] cmd, input logic [15:0] wd, input int nOut, input int nIn,
                     input logic [15:0] exp);
    expQ.push_back({1'b1, exp});
    tcp_host_model_i.xfer(cmd, wd, nOut, nIn);
  endtask

  task automatic waitBusy(input logic lvl, input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while (convBusy !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("ERROR %0t busy wait ran out", $time);
        final_report();
      end
    end
  endtask

  always @(posedge resValid) begin
    check(resWord, expQ.pop_front());
  end

  // length of the last busy stretch and number of stretches; sampled off the launching edge
  always @(negedge core_clk) begin
    if (convBusy === 1'b1) begin
      busyRun <= busyRun + 1;
    end else if (busyRun != 0) begin
      busyLen <= busyRun;
      busyRun <= 0;
      convEnds <= convEnds + 1;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #900000;
    err_count++;
    $display("ERROR %0t run did not finish", $time);
    final_report();
  end

  initial begin
    logic [11:0] t;
    int e0;
    rst = 1'b1;
    sensorTemp = '0;
    rng = 32'h55;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    run(CMD_FETCH_SETUP, '0, 0, 16, 16'h008c);
    run(CMD_FETCH_TEMP, '0, 0, 16, 16'h0000);
    // sixteen bits sent to the high limit: the top four must be dropped
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      run(CMD_STORE_UPPER_LIMIT, rng[15:0], 16, 0, 'x);
      run(CMD_FETCH_UPPER_LIMIT, '0, 0, 16, {4'h0, rng[11:0]});
      run(CMD_STORE_LOWER_LIMIT, rng[31:16], 12, 0, 'x);
      run(CMD_FETCH_LOWER_LIMIT, '0, 0, 16, {4'h0, rng[27:16]});
    end
    run(CMD_STORE_LOWER_LIMIT, 16'h0555, 11, 0, 'x);
    run(CMD_FETCH_LOWER_LIMIT, '0, 0, 16, {4'h0, rng[27:16]});
    // read-only bits written as ones must not stick
    run(CMD_STORE_SETUP, 16'hff91, 8, 0, 'x);
    run(CMD_FETCH_SETUP, '0, 0, 16, 16'h0081);
    run(CMD_STORE_UPPER_LIMIT, 16'h07ff, 12, 0, 'x);
    run(CMD_FETCH_UPPER_LIMIT, '0, 0, 16, 16'h07f8);
    run(CMD_STORE_LOWER_LIMIT, 16'h0800, 12, 0, 'x);
    // one-shot, 9-bit; temperature kept between both limits
    rng = xs(rng);
    t = {2'b00, rng[9:0]};
    @(posedge core_clk);
    sensorTemp <= t;
    e0 = convEnds;
    run(CMD_START_CONV, '0, 0, 8, 'x);
    repeat (50) @(posedge core_clk);
    @(negedge core_clk);
    check(17'(convBusy), 17'h0);
    check(17'(convEnds - e0), 17'h1);
    check(17'(busyLen inside {BASE, BASE + 1}), 17'h1);
    run(CMD_FETCH_TEMP, '0, 0, 16, {4'h0, t & 12'hff8});
    run(CMD_FETCH_SETUP, '0, 0, 16, 16'h0081);
    // continuous, 10-bit: a later temperature must be picked up
    run(CMD_STORE_SETUP, 16'h0004, 8, 0, 'x);
    run(CMD_START_CONV, '0, 0, 0, 'x);
    repeat (300) @(posedge core_clk);
    rng = xs(rng);
    sensorTemp <= {2'b01, rng[9:0]};
    repeat (100) @(posedge core_clk);
    @(negedge core_clk);
    check(17'(convBusy), 17'h1);
    run(CMD_STOP_CONV, '0, 0, 8, 'x);
    waitBusy(1'b0, 100);
    run(CMD_FETCH_TEMP, '0, 0, 16, {6'h01, rng[9:2], 2'h0});
    // software reset in mid-run
    run(CMD_START_CONV, '0, 0, 0, 'x);
    waitBusy(1'b1, 100);
    run(CMD_SOFT_POR, '0, 0, 8, 'x);
    waitBusy(1'b0, 10);
    run(CMD_FETCH_SETUP, '0, 0, 16, 16'h0084);
    run(CMD_FETCH_TEMP, '0, 0, 16, 16'h0000);
    run(CMD_FETCH_UPPER_LIMIT, '0, 0, 16, 16'h07f8);
    run(8'h33, '0, 0, 16, 'x);
    check(17'(expQ.size()), 17'h0);
    final_report();
  end
endmodule
